// file: hdl/dsc_defines.vh
// field positions, codes, limits and register offsets of the drum controller
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH

// function and status word fields
`define DSC_CODE_HI      29
`define DSC_CODE_LO      24
`define DSC_UNIT_HI      22
`define DSC_UNIT_LO      20
`define DSC_POS_HI       19
`define DSC_POS_LO       12
`define DSC_TRK_HI       11
`define DSC_TRK_LO       6
`define DSC_SEC_HI       5
`define DSC_SEC_LO       0

// operation codes (octal values written in hex)
`define DSC_OP_WRITE     6'h0A
`define DSC_OP_READ      6'h2A
`define DSC_OP_POS       6'h10
`define DSC_OP_POS_INT   6'h18
`define DSC_OP_SALL_L    6'h2E
`define DSC_OP_SALL_S    6'h2F
`define DSC_OP_SFIRST_L  6'h2C
`define DSC_OP_SFIRST_S  6'h2D
`define DSC_OP_RECOVER   6'h2B
`define DSC_OP_TERM      6'h13
`define DSC_OP_TERM_INT  6'h1B

// completion codes (octal values written in hex)
`define DSC_SC_TIMEOUT   6'h04
`define DSC_SC_EOP_IN    6'h05
`define DSC_SC_PHASE     6'h06
`define DSC_SC_NONREC    6'h07
`define DSC_SC_RECOVER   6'h08
`define DSC_SC_ADDR      6'h0C
`define DSC_SC_SEQ       6'h10
`define DSC_SC_EOP_OUT   6'h14
`define DSC_SC_LENGTH    6'h1C
`define DSC_SC_NORMAL    6'h20
`define DSC_SC_BADCODE   6'h28
`define DSC_SC_BADADDR   6'h2C
`define DSC_SC_WRFAULT   6'h30
`define DSC_SC_NOTREADY  6'h3C

// geometry limits
`define DSC_SEC_LAST     6'h3F
`define DSC_TRK_LAST     6'h3F
`define DSC_POS_LAST     8'h5F
`define DSC_SEC_WORDS    6'h21
`define DSC_SHORT_LAST   6'h3F

// register offsets and reset values
`define DSC_REG_CFG      4'h0
`define DSC_REG_STATE    4'h1
`define DSC_REG_STAT     4'h2
`define DSC_REG_IDENT    4'h3
`define DSC_CFG_RST      8'hFF

`endif

// file: hdl/dsc_sync.v
// two-flop synchroniser for a vector of independent levels
`timescale 1ns/10ps
module dsc_sync #(
	parameter WIDTH = 12
) (
	// clock and reset
	input  wire             clk_sys,
	input  wire             rstn,
	// levels
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_reg;
			reg sync_reg;
			always @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= async_in[i];
					sync_reg <= meta_reg;
				end
			end
			assign sync_out[i] = sync_reg;
		end
	endgenerate

endmodule // dsc_sync

// file: hdl/dsc_ctrl.v
// drum store command decoder, transfer sequencer and status reporter
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "dsc_defines.vh"
module dsc_ctrl (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rstn,
	// processor channel, inbound
	input  wire [29:0] hi_fw,
	input  wire        hi_fw_stb,
	input  wire [29:0] hi_out_word,
	input  wire        hi_out_stb,
	input  wire        hi_in_ack,
	// processor channel, outbound
	output reg  [29:0] ho_in_word,
	output reg         ho_in_valid,
	output reg         ho_out_req,
	output reg  [29:0] ho_stat_word,
	output reg         ho_stat_stb,
	output reg         ho_ext_int,
	// drum units, inbound
	input  wire [29:0] dr_word,
	input  wire        dr_word_stb,
	input  wire        dr_sector_end,
	input  wire        dr_wr_req,
	input  wire        dr_seek_done,
	input  wire        dr_phase_err,
	input  wire        dr_lpar_err,
	input  wire        dr_addr_missing,
	input  wire        dr_write_fault,
	input  wire        dr_ready,
	// drum units, outbound
	output reg  [22:0] drum_addr,
	output reg         drum_seek,
	output reg         drum_read,
	output reg         drum_write,
	output reg  [29:0] drum_wr_word,
	output reg         drum_wr_stb,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_IDW  = 4'b0010;
	localparam ST_SEEK = 4'b0100;
	localparam ST_XFER = 4'b1000;

	wire [11:0] raw_in;
	wire [11:0] syn_in;
	reg  [11:0] syn_prev_reg;
	wire [11:0] edge_in;

	reg  [3:0]  st_reg;
	reg  [7:0]  cfg_units_reg;
	reg  [29:0] ident_reg;
	reg  [29:0] last_stat_reg;
	reg  [29:0] out_buf_reg;
	reg         out_full_reg;
	reg         wr_mode_reg;
	reg         rec_mode_reg;
	reg         srch_reg;
	reg         srch_first_reg;
	reg         srch_short_reg;
	reg         int_req_reg;
	reg         term_pend_reg;
	reg         term_int_reg;
	reg  [5:0]  wcnt_reg;
	reg  [5:0]  scnt_reg;
	reg  [1:0]  phase_cnt_reg;
	reg         lpar_reg;

	wire [5:0]  fc;
	wire [2:0]  fw_unit;
	wire [7:0]  fw_pos;
	wire        e_fw;
	wire        e_out;
	wire        e_ack;
	wire        e_word;
	wire        e_send;
	wire        e_wreq;
	wire        e_seek;
	wire        e_phase;
	wire        e_lpar;
	wire        e_amiss;
	wire        e_wfault;
	wire        ready_s;
	wire        word_hit;

	// every pin strobe passes the synchroniser; data words are held stable
	// by the sender while its strobe is high, so they are sampled directly
	assign raw_in = {dr_ready, dr_write_fault, dr_addr_missing, dr_lpar_err,
		dr_phase_err, dr_seek_done, dr_wr_req, dr_sector_end, dr_word_stb,
		hi_in_ack, hi_out_stb, hi_fw_stb};

	dsc_sync #(
		.WIDTH    (12)
	) u_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.async_in (raw_in),
		.sync_out (syn_in)
	);

	assign edge_in  = syn_in & ~syn_prev_reg;
	assign e_fw     = edge_in[0];
	assign e_out    = edge_in[1];
	assign e_ack    = edge_in[2];
	assign e_word   = edge_in[3];
	assign e_send   = edge_in[4];
	assign e_wreq   = edge_in[5];
	assign e_seek   = edge_in[6];
	assign e_phase  = edge_in[7];
	assign e_lpar   = edge_in[8];
	assign e_amiss  = edge_in[9];
	assign e_wfault = edge_in[10];
	assign ready_s  = syn_in[11];

	assign fc      = hi_fw[`DSC_CODE_HI:`DSC_CODE_LO];
	assign fw_unit = hi_fw[`DSC_UNIT_HI:`DSC_UNIT_LO];
	assign fw_pos  = hi_fw[`DSC_POS_HI:`DSC_POS_LO];

	// searching compares every word, or only word 0 in first-word mode
	assign word_hit = (dr_word == ident_reg) &&
		(!srch_first_reg || wcnt_reg == 6'h00);

	function fc_valid;
		input [5:0] code;
		begin
			fc_valid = (code == `DSC_OP_WRITE) || (code == `DSC_OP_READ) ||
				(code == `DSC_OP_POS) || (code == `DSC_OP_POS_INT) ||
				(code == `DSC_OP_SALL_L) || (code == `DSC_OP_SALL_S) ||
				(code == `DSC_OP_SFIRST_L) || (code == `DSC_OP_SFIRST_S) ||
				(code == `DSC_OP_RECOVER) || (code == `DSC_OP_TERM) ||
				(code == `DSC_OP_TERM_INT);
		end
	endfunction

	function [29:0] mk_stat;
		input [5:0]  code;
		input [22:0] addr;
		input        with_addr;
		begin
			mk_stat = {code, 1'b0, with_addr ? addr : 23'h000000};
		end
	endfunction

	// ends the operation; later calls in a cycle override earlier ones, so
	// the code below is ordered from low to high priority
	task finish;
		input [5:0] code;
		input       send;
		input       with_addr;
		begin
			st_reg        <= ST_IDLE;
			drum_seek     <= 1'b0;
			drum_read     <= 1'b0;
			drum_write    <= 1'b0;
			ho_in_valid   <= 1'b0;
			out_full_reg  <= 1'b0;
			srch_reg      <= 1'b0;
			wr_mode_reg   <= 1'b0;
			rec_mode_reg  <= 1'b0;
			term_pend_reg <= 1'b0;
			if (send) begin
				ho_stat_word  <= mk_stat(code, drum_addr, with_addr);
				last_stat_reg <= mk_stat(code, drum_addr, with_addr);
				ho_stat_stb   <= 1'b1;
				ho_ext_int    <= 1'b1;
			end
		end
	endtask

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syn_prev_reg   <= 12'h000;
			st_reg         <= ST_IDLE;
			ident_reg      <= 30'h00000000;
			last_stat_reg  <= 30'h00000000;
			out_buf_reg    <= 30'h00000000;
			out_full_reg   <= 1'b0;
			wr_mode_reg    <= 1'b0;
			rec_mode_reg   <= 1'b0;
			srch_reg       <= 1'b0;
			srch_first_reg <= 1'b0;
			srch_short_reg <= 1'b0;
			int_req_reg    <= 1'b0;
			term_pend_reg  <= 1'b0;
			term_int_reg   <= 1'b0;
			wcnt_reg       <= 6'h00;
			scnt_reg       <= 6'h00;
			phase_cnt_reg  <= 2'h0;
			lpar_reg       <= 1'b0;
			ho_in_word     <= 30'h00000000;
			ho_in_valid    <= 1'b0;
			ho_out_req     <= 1'b0;
			ho_stat_word   <= 30'h00000000;
			ho_stat_stb    <= 1'b0;
			ho_ext_int     <= 1'b0;
			drum_addr      <= 23'h000000;
			drum_seek      <= 1'b0;
			drum_read      <= 1'b0;
			drum_write     <= 1'b0;
			drum_wr_word   <= 30'h00000000;
			drum_wr_stb    <= 1'b0;
		end else begin
			syn_prev_reg <= syn_in;
			ho_out_req   <= 1'b0;
			ho_stat_stb  <= 1'b0;
			ho_ext_int   <= 1'b0;
			drum_wr_stb  <= 1'b0;
			if (e_ack) begin
				ho_in_valid <= 1'b0;
			end
			if (e_out) begin
				out_buf_reg  <= hi_out_word;
				out_full_reg <= 1'b1;
			end
			if (st_reg == ST_XFER && e_phase && phase_cnt_reg != 2'h3) begin
				phase_cnt_reg <= phase_cnt_reg + 2'h1;
			end
			if (st_reg == ST_XFER && e_lpar) begin
				lpar_reg <= 1'b1;
			end
			// read side word stream
			if (st_reg == ST_XFER && !wr_mode_reg && e_word) begin
				if (wcnt_reg == `DSC_SEC_WORDS) begin
					finish(`DSC_SC_LENGTH, 1'b1, 1'b1);
				end else begin
					wcnt_reg <= wcnt_reg + 6'h01;
					if (!srch_reg || word_hit) begin
						srch_reg <= 1'b0;
						if (ho_in_valid && !e_ack) begin
							finish(`DSC_SC_TIMEOUT, 1'b1, 1'b0);
						end else begin
							ho_in_word  <= dr_word;
							ho_in_valid <= 1'b1;
						end
					end
				end
			end
			// write side word requests
			if (st_reg == ST_XFER && wr_mode_reg && e_wreq) begin
				if (wcnt_reg == `DSC_SEC_WORDS) begin
					finish(`DSC_SC_LENGTH, 1'b1, 1'b1);
				end else if (out_full_reg) begin
					drum_wr_word <= out_buf_reg;
					drum_wr_stb  <= 1'b1;
					out_full_reg <= e_out;
					ho_out_req   <= 1'b1;
					wcnt_reg     <= wcnt_reg + 6'h01;
				end else begin
					finish(`DSC_SC_SEQ, 1'b1, 1'b0);
				end
			end
			// sector boundary: check, stop or advance
			if (st_reg == ST_XFER && e_send) begin
				wcnt_reg      <= 6'h00;
				phase_cnt_reg <= 2'h0;
				lpar_reg      <= 1'b0;
				scnt_reg      <= scnt_reg + 6'h01;
				if (!wr_mode_reg && (phase_cnt_reg[1] ||
					(lpar_reg && phase_cnt_reg == 2'h0))) begin
					finish(`DSC_SC_NONREC, 1'b1, 1'b1);
				end else if (!wr_mode_reg && phase_cnt_reg == 2'h1) begin
					finish(`DSC_SC_PHASE, 1'b1, 1'b1);
				end else if (rec_mode_reg) begin
					finish(`DSC_SC_RECOVER, 1'b1, 1'b0);
				end else if (wr_mode_reg && term_pend_reg) begin
					finish(`DSC_SC_NORMAL, term_int_reg, 1'b0);
				end else if (srch_reg && srch_short_reg &&
					scnt_reg == `DSC_SHORT_LAST) begin
					finish(`DSC_SC_EOP_IN, 1'b1, 1'b1);
				end else if (drum_addr[`DSC_SEC_HI:`DSC_SEC_LO] !=
					`DSC_SEC_LAST) begin
					drum_addr[`DSC_SEC_HI:`DSC_SEC_LO] <=
						drum_addr[`DSC_SEC_HI:`DSC_SEC_LO] + 6'h01;
				end else if (drum_addr[`DSC_TRK_HI:`DSC_TRK_LO] !=
					`DSC_TRK_LAST) begin
					drum_addr[`DSC_SEC_HI:`DSC_SEC_LO] <= 6'h00;
					drum_addr[`DSC_TRK_HI:`DSC_TRK_LO] <=
						drum_addr[`DSC_TRK_HI:`DSC_TRK_LO] + 6'h01;
				end else begin
					// moving to the next position needs a head change
					finish(wr_mode_reg ? `DSC_SC_EOP_OUT : `DSC_SC_EOP_IN,
						1'b1, 1'b1);
				end
			end
			if (st_reg == ST_SEEK && e_seek) begin
				finish(`DSC_SC_NORMAL, int_req_reg, 1'b0);
			end
			if (st_reg == ST_XFER && wr_mode_reg && e_wfault) begin
				finish(`DSC_SC_WRFAULT, 1'b1, 1'b1);
			end
			if (st_reg != ST_IDLE && st_reg != ST_IDW && e_amiss) begin
				finish(`DSC_SC_ADDR, 1'b1, 1'b1);
			end
			// function words from the processor
			if (e_fw && st_reg == ST_IDW) begin
				ident_reg <= hi_fw;
				st_reg    <= ST_XFER;
				drum_read <= 1'b1;
			end else if (e_fw && (fc == `DSC_OP_TERM ||
				fc == `DSC_OP_TERM_INT)) begin
				if (st_reg == ST_XFER && wr_mode_reg) begin
					term_pend_reg <= 1'b1;
					term_int_reg  <= (fc == `DSC_OP_TERM_INT);
				end else begin
					if (st_reg == ST_XFER) begin
						ho_out_req <= 1'b1;
					end
					finish(`DSC_SC_NORMAL, fc == `DSC_OP_TERM_INT,
						1'b0);
				end
			end else if (e_fw && st_reg == ST_IDLE) begin
				wcnt_reg       <= 6'h00;
				scnt_reg       <= 6'h00;
				phase_cnt_reg  <= 2'h0;
				lpar_reg       <= 1'b0;
				drum_addr      <= hi_fw[`DSC_UNIT_HI:`DSC_SEC_LO];
				int_req_reg    <= (fc == `DSC_OP_POS_INT);
				srch_first_reg <= (fc == `DSC_OP_SFIRST_L) ||
					(fc == `DSC_OP_SFIRST_S);
				srch_short_reg <= (fc == `DSC_OP_SALL_S) ||
					(fc == `DSC_OP_SFIRST_S);
				if (!fc_valid(fc)) begin
					finish(`DSC_SC_BADCODE, 1'b1, 1'b0);
				end else if (!ready_s) begin
					finish(`DSC_SC_NOTREADY, 1'b1, 1'b0);
				end else if (!cfg_units_reg[fw_unit] ||
					fw_pos > `DSC_POS_LAST) begin
					finish(`DSC_SC_BADADDR, 1'b1, 1'b0);
				end else if (fc == `DSC_OP_WRITE) begin
					st_reg       <= ST_XFER;
					wr_mode_reg  <= 1'b1;
					drum_write   <= 1'b1;
					out_full_reg <= 1'b0;
					ho_out_req   <= 1'b1;
				end else if (fc == `DSC_OP_POS || fc == `DSC_OP_POS_INT) begin
					st_reg    <= ST_SEEK;
					drum_seek <= 1'b1;
				end else if (fc == `DSC_OP_READ || fc == `DSC_OP_RECOVER) begin
					st_reg       <= ST_XFER;
					drum_read    <= 1'b1;
					rec_mode_reg <= (fc == `DSC_OP_RECOVER);
				end else begin
					st_reg   <= ST_IDW;
					srch_reg <= 1'b1;
				end
			end
		end
	end

	// register port: data answers in the cycle after the read strobe only
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_units_reg <= `DSC_CFG_RST;
			reg_rdata     <= 32'h00000000;
		end else begin
			if (reg_wr && reg_addr == `DSC_REG_CFG) begin
				cfg_units_reg <= reg_wdata[7:0];
			end
			if (!reg_rd) begin
				reg_rdata <= 32'h00000000;
			end else if (reg_addr == `DSC_REG_CFG) begin
				reg_rdata <= {24'h000000, cfg_units_reg};
			end else if (reg_addr == `DSC_REG_STATE) begin
				reg_rdata <= {22'h000000, srch_reg, wr_mode_reg,
					rec_mode_reg, term_pend_reg, out_full_reg, ho_in_valid,
					st_reg};
			end else if (reg_addr == `DSC_REG_STAT) begin
				reg_rdata <= {2'h0, last_stat_reg};
			end else if (reg_addr == `DSC_REG_IDENT) begin
				reg_rdata <= {2'h0, ident_reg};
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end
	end

endmodule // dsc_ctrl

// file: verification/dsc_ctrl_properties.sv
// port-level assertions for the drum controller
`timescale 1ns/10ps
module dsc_ctrl_properties (
	// clock and reset
	input wire        clk_sys,
	input wire        rstn,
	// channel and drum outputs
	input wire [29:0] ho_stat_word,
	input wire        ho_stat_stb,
	input wire        ho_ext_int,
	input wire        ho_in_valid,
	input wire        ho_out_req,
	input wire [22:0] drum_addr,
	input wire        drum_seek,
	input wire        drum_read,
	input wire        drum_write,
	input wire        drum_wr_stb
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	a_int_with_stat: assert property (ho_ext_int == ho_stat_stb)
		else $error("interrupt and status differ");
	a_stat_one_cycle: assert property (ho_stat_stb |=> !ho_stat_stb)
		else $error("status pulse too long");
	a_stat_bit_clear: assert property (ho_stat_stb |-> !ho_stat_word[23])
		else $error("status bit 23 set");
	a_plain_no_addr: assert property (ho_stat_stb &&
		ho_stat_word[29:24] inside {6'h08, 6'h10, 6'h20, 6'h28, 6'h3C}
		|-> ho_stat_word[22:0] == 23'h0)
		else $error("address in plain status");
	a_error_stops: assert property (ho_stat_stb &&
		ho_stat_word[29:24] inside {6'h04, 6'h06, 6'h07, 6'h1C}
		|-> ##[0:2] !drum_read)
		else $error("read goes on after error");
	a_seek_alone: assert property (drum_seek |-> !drum_read && !drum_write)
		else $error("data moves during seek");
	a_write_strobe: assert property (drum_wr_stb |-> drum_write)
		else $error("write word outside write");
	a_read_deliver: assert property ($rose(ho_in_valid) |-> drum_read)
		else $error("word delivered outside read");
	a_sector_step: assert property (drum_read && $past(drum_read) &&
		drum_addr != $past(drum_addr)
		|-> drum_addr[11:0] == $past(drum_addr[11:0]) + 12'h001)
		else $error("sector address skipped");
	a_req_one_cycle: assert property (ho_out_req |=> !ho_out_req)
		else $error("output request too long");
endmodule // dsc_ctrl_properties
bind dsc_ctrl dsc_ctrl_properties u_props (.*);

// file: verification/dsc_chan_model.sv
// processor channel model: takes read words, hands out write words
`timescale 1ns/10ps
module dsc_chan_model #(
	parameter logic [29:0] BASE = 30'h0ABC000
) (
	// clock and reset
	input  wire         clk_sys,
	input  wire         rstn,
	// from the controller
	input  wire  [29:0] ho_in_word,
	input  wire         ho_in_valid,
	input  wire         ho_out_req,
	// lag 0 never accepts; limit caps the total of words served since reset
	input  wire  [31:0] lag,
	input  wire  [31:0] limit,
	// to the controller
	output logic [29:0] hi_out_word,
	output logic        hi_out_stb,
	output logic        hi_in_ack,
	// accepted words
	output logic [29:0] got,
	output int          ngot
);
	int served;
	initial begin
		{hi_in_ack, got, ngot} = '0;
		forever begin
			@(posedge clk_sys);
			if (rstn && ho_in_valid && lag != 0) begin
				repeat (lag) @(posedge clk_sys);
				got <= ho_in_word;
				ngot <= ngot + 1;
				hi_in_ack <= 1'b1;
				repeat (3) @(posedge clk_sys);
				hi_in_ack <= 1'b0;
				repeat (3) @(posedge clk_sys);
			end
		end
	end
	// block ends when the count meets the limit, later requests go unserved
	initial begin
		{hi_out_stb, hi_out_word, served} = '0;
		forever begin
			@(posedge clk_sys);
			if (rstn && ho_out_req && served < limit) begin
				hi_out_word <= 30'(BASE + served);
				hi_out_stb <= 1'b1;
				repeat (3) @(posedge clk_sys);
				hi_out_stb <= 1'b0;
				hi_out_word <= ~30'(BASE + served);
				served++;
				repeat (3) @(posedge clk_sys);
			end
		end
	end
endmodule // dsc_chan_model

// file: verification/dsc_ctrl_test.sv
// self-checking bench for the drum controller
`timescale 1ns/10ps
module dsc_ctrl_test;
	localparam logic [29:0] ID = {6'h1C, 1'b0, 23'h2A5A5A};
	localparam logic [29:0] WA = 30'h2345678;
	localparam logic [29:0] BASE = 30'h0ABC000;
	localparam logic [22:0] A2 = {3'h1, 8'h05, 6'h04, 6'h3F};
	localparam logic [22:0] A3 = {3'h0, 8'h01, 6'h02, 6'h00};
	logic        clk_sys, rstn, hi_fw_stb, hi_out_stb, hi_in_ack;
	logic        ho_in_valid, ho_out_req, ho_stat_stb, ho_ext_int;
	logic        dr_word_stb, dr_sector_end, dr_wr_req, dr_seek_done;
	logic        dr_phase_err, dr_lpar_err, dr_ready, dr_addr_missing;
	logic        dr_write_fault, drum_seek, drum_read, drum_write;
	logic        drum_wr_stb, reg_wr, reg_rd;
	logic [29:0] hi_fw, hi_out_word, ho_in_word, ho_stat_word, dr_word;
	logic [29:0] drum_wr_word, got, sw, wrw;
	logic [22:0] drum_addr;
	logic [7:0]  dv;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, lag, limit;
	int          miscompares, checks, sn, en, nreq, ngot, n;
	assign {dr_write_fault, dr_addr_missing, dr_lpar_err, dr_phase_err,
		dr_seek_done, dr_wr_req, dr_sector_end, dr_word_stb} = dv;
	dsc_ctrl DUT (.*);
	dsc_chan_model #(.BASE(BASE)) u_chan (.*);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (ho_stat_stb) begin
			sw <= ho_stat_word;
			sn <= sn + 1;
		end
		if (drum_wr_stb)
			wrw <= drum_wr_word;
		if (ho_out_req)
			nreq <= nreq + 1;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// pins pass a synchroniser, so each level is held four cycles
	task fw(input logic [5:0] c, input logic [22:0] a);
		hi_fw <= {c, 1'b0, a};
		hi_fw_stb <= 1'b1;
		repeat (4) @(posedge clk_sys);
		hi_fw_stb <= 1'b0;
		hi_fw <= ~{c, 1'b0, a};
		repeat (4) @(posedge clk_sys);
	endtask
	task ev(input int b);
		dv[b] <= 1'b1;
		repeat (4) @(posedge clk_sys);
		dv[b] <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	task dw(input logic [29:0] w);
		dr_word <= w;
		ev(0);
		dr_word <= ~w;
		repeat (2) @(posedge clk_sys);
	endtask
	task st(input logic [5:0] c, input logic [22:0] a);
		en++;
		chk(sn, en);
		chk(sw, {c, 1'b0, a});
	endtask
	task rg(input logic wr, input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge clk_sys);
		{reg_wr, reg_rd} <= 2'b00;
		@(posedge clk_sys);
		if (!wr)
			chk(reg_rdata, d);
	endtask
	task t_regs;
		rg(1'b0, 4'h0, 32'hFF);
		rg(1'b0, 4'h1, 32'h1);
		rg(1'b1, 4'h2, 32'h5);
		rg(1'b0, 4'h2, 32'h0);
		rg(1'b0, 4'h7, 32'h0);
		rg(1'b1, 4'h0, 32'hFE);
		fw(6'h0A, 23'h0);
		st(6'h2C, 23'h0);
		rg(1'b1, 4'h0, 32'hFF);
	endtask
	task t_refuse;
		fw(6'h01, A2);
		st(6'h28, 23'h0);
		fw(6'h2A, {3'h1, 8'h60, 12'h0});
		st(6'h2C, 23'h0);
		dr_ready <= 1'b0;
		fw(6'h2A, A2);
		st(6'h3C, 23'h0);
		dr_ready <= 1'b1;
	endtask
	task t_pos;
		fw(6'h10, {3'h2, 8'h5F, 12'h3C7});
		chk(drum_seek, 1);
		chk(drum_addr, {3'h2, 8'h5F, 12'h3C7});
		ev(3);
		chk(sn, en);
		fw(6'h18, A2);
		ev(3);
		st(6'h20, 23'h0);
	endtask
	task t_read;
		fw(6'h2A, A2);
		dw(WA);
		chk(got, WA);
		ev(1);
		chk(drum_addr, {3'h1, 8'h05, 6'h05, 6'h00});
		n = nreq;
		fw(6'h1B, 23'h0);
		st(6'h20, 23'h0);
		chk(nreq, n + 1);
		chk(drum_read, 0);
	endtask
	task t_ends;
		lag <= 0;
		fw(6'h2A, A2);
		dw(WA);
		dw(WA);
		st(6'h04, 23'h0);
		lag <= 1;
		fw(6'h2B, A2);
		dw(WA);
		ev(1);
		st(6'h08, 23'h0);
		fw(6'h2A, A2);
		repeat (34) dw(WA);
		st(6'h1C, A2);
	endtask
	task t_errs;
		logic [5:0] cd [4] = '{6'h06, 6'h07, 6'h0C, 6'h30};
		for (int i = 0; i < 4; i++) begin
			fw(i == 3 ? 6'h0A : 6'h2A, A2);
			ev(4 + i);
			if (i < 2)
				ev(1);
			st(cd[i], A2);
		end
	endtask
	task t_search;
		for (int i = 0; i < 2; i++) begin
			fw(i ? 6'h2C : 6'h2E, A2);
			fw(ID[29:24], ID[22:0]);
			n = ngot;
			dw(~ID);
			dw(ID);
			if (i) begin
				ev(1);
				dw(ID);
			end
			chk(ngot, n + 1);
			chk(got, ID);
			dw(WA);
			chk(got, WA);
			fw(6'h13, 23'h0);
		end
		rg(1'b0, 4'h3, {2'b00, ID});
		for (int i = 0; i < 2; i++) begin
			fw(i ? 6'h2D : 6'h2F, A3);
			fw(ID[29:24], ID[22:0]);
			repeat (63) ev(1);
			chk(sn, en);
			ev(1);
			st(6'h05, {A3[22:6], 6'h3F});
		end
	endtask
	task t_write;
		limit <= 1;
		fw(6'h0A, A3);
		ev(2);
		chk(wrw, BASE);
		fw(6'h13, 23'h0);
		chk(drum_write, 1);
		ev(1);
		chk(drum_write, 0);
		chk(sn, en);
		limit <= 2;
		fw(6'h0A, A3);
		ev(2);
		chk(wrw, BASE + 1);
		ev(2);
		st(6'h10, 23'h0);
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// whole run needs well under ten thousand cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		miscompares++;
		test_done;
	end
	initial begin
		{rstn, hi_fw, hi_fw_stb, dr_word, dv, reg_addr} = '0;
		{reg_wdata, reg_wr, reg_rd, limit} = '0;
		dr_ready = 1'b1;
		lag = 1;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_regs;
		t_refuse;
		t_pos;
		t_read;
		t_ends;
		t_errs;
		t_search;
		t_write;
		test_done;
	end
endmodule // dsc_ctrl_test
